/* File: hdl/psx_exec.sv */
`timescale 1ns/1ps
// What this block does
// RL1: Set-product-mode copies instruction bits 1:0 into status word one bits 1:0.
// RL2: Mode 00 no shift, 01 left 1, 10 left 4, 11 right 6 signed.
// RL3: Product readers see the shifted product; stored product stays unmodified.
// RL4: Load-status-one also writes the product shift mode field.
// RL5: Set-product-mode costs 1 cycle, or 1 plus program waits externally.
// RL6: Store-status writes status word zero or one, chosen by opcode bit 8.
// RL7: Direct store-status targets page 0; page pointer left untouched.
// RL8: Indirect store-status uses the auxiliary register address, any page.
// RL9: Store-status costs 1, 2+d, 4+d+p; repeated 2n+nd external.
// RL10: Square ops cost 1, 1+d, or 2+d+p.
// RL11: Repeated square ops cost n or n+nd, plus one when code/operand collide.
// RL12: Store-long-immediate costs 2, 3 shared, 3+d external, 5+d+2p all external.
// RL13: Square ops accumulate or subtract shifted product, load multiplicand, square it.
// RL14: Store-long-immediate writes the second instruction word unchanged to memory.
module psx_exec (
  input  wire logic                    clk,           // 20 MHz core clock
  input  wire logic                    nrst,          // Async reset, active low
  input  wire logic                    instr_valid,   // Instruction word present
  input  wire logic [15:0]             instr,         // Instruction word
  input  wire logic [15:0]             instr_ext,     // Second word for long immediate
  input  wire logic [7:0]              rpt_n,         // Repeat count n (0 = single)
  input  wire psx_pkg::psx_mem_s       mem,           // Memory placement and waits
  input  wire logic [8:0]              dp_in,         // Data page pointer
  input  wire logic [15:0]             ar_in,         // Selected auxiliary register
  input  wire logic [15:0]             rd_data,       // Operand read from data memory
  input  wire logic [15:0]             lst_data,      // Status word one load value
  output logic                         busy,          // Instruction still executing
  output logic [7:0]                   cycles_q,      // Cycle cost of last instruction
  output logic                         wr_en_q,       // Data memory write
  output logic [15:0]                  wr_addr_q,     // Data memory write address
  output logic [15:0]                  wr_data_q,     // Data memory write data
  output logic [15:0]                  rd_addr,       // Operand address
  output logic [31:0]                  acc_q,         // Accumulator
  output logic [15:0]                  multiplicand_register_q,        // Multiplicand register
  output logic [31:0]                  product_register_q,        // Product register
  output logic [31:0]                  product_register_shifted,  // Shifted product view
  output logic [15:0]                  st0_q,         // Status word zero
  output logic [15:0]                  st1_q          // Status word one
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic psx_pkg::psx_op_e decode(input logic [15:0] w);
    if (w[15:2] == psx_pkg::OP_SPM_HI) begin
      decode = psx_pkg::PSX_OP_SPM;
    end else if (w[15:8] == psx_pkg::OP_SQUARE_ACCUMULATE_OP_HI) begin
      decode = psx_pkg::PSX_OP_SQUARE_ACCUMULATE_OP;
    end else if (w[15:8] == psx_pkg::OP_SQUARE_SUBTRACT_OP_HI) begin
      decode = psx_pkg::PSX_OP_SQUARE_SUBTRACT_OP;
    end else if (w[15:8] == psx_pkg::OP_STORE_LONG_IMMEDIATE_OP_HI) begin
      decode = psx_pkg::PSX_OP_STORE_LONG_IMMEDIATE_OP;
    end else if (w[15:9] == psx_pkg::OP_SST_HI) begin
      decode = psx_pkg::PSX_OP_SST;
    end else if (w[15:8] == psx_pkg::OP_LST1_HI) begin
      decode = psx_pkg::PSX_OP_LST1;
    end else begin
      decode = psx_pkg::PSX_OP_NONE;
    end
  endfunction : decode

  psx_pkg::psx_op_e op;
  logic             ind;
  logic [15:0]      ea;

  always_comb begin
    op  = instr_valid ? decode(instr) : psx_pkg::PSX_OP_NONE;
    ind = instr[psx_pkg::IND_BIT];
    ea  = ind ? ar_in : {dp_in, instr[6:0]};                   // [RL8]
    if (op == psx_pkg::PSX_OP_SST && !ind) begin
      ea = {9'h000, instr[6:0]};                               // [RL7]
    end
    rd_addr = ea;
  end

  // ****************************************
  // Product shifter
  // ****************************************
  always_comb begin
    case (st1_q[psx_pkg::PM_LSB +: 2])                         // [RL2]
      2'b01:   product_register_shifted = product_register_q << psx_pkg::SHL1;
      2'b10:   product_register_shifted = product_register_q << psx_pkg::SHL4;
      2'b11:   product_register_shifted = $signed(product_register_q) >>> psx_pkg::SHR6;
      default: product_register_shifted = product_register_q;
    endcase
  end

  // ****************************************
  // Cycle cost
  // ****************************************
  logic [7:0] cost;
  logic [7:0] n, nd, pw, dw;

  always_comb begin
    n    = rpt_n;
    pw   = {4'h0, mem.p_wait};
    dw   = {4'h0, mem.d_wait};
    nd   = 8'(n * dw);
    cost = psx_pkg::CYC_ONE;
    case (op)
      psx_pkg::PSX_OP_SPM: begin
        cost = mem.code_ext ? 8'(psx_pkg::CYC_ONE + pw) : psx_pkg::CYC_ONE;   // [RL5]
      end
      psx_pkg::PSX_OP_SQUARE_ACCUMULATE_OP, psx_pkg::PSX_OP_SQUARE_SUBTRACT_OP: begin
        if (n != 8'h00) begin                                                  // [RL11]
          if (mem.opnd_ext && mem.code_ext) begin
            cost = 8'(n + 8'h01 + pw + nd);
          end else if (mem.opnd_ext) begin
            cost = 8'(n + nd);
          end else if (mem.code_ext) begin
            cost = 8'(n + pw);
          end else begin
            cost = mem.same_single_access_ram ? 8'(n + 8'h01) : n;
          end
        end else if (mem.opnd_ext) begin                                       // [RL10]
          cost = mem.code_ext ? 8'(psx_pkg::CYC_SQR_ALL + dw + pw)
                              : 8'(psx_pkg::CYC_ONE + dw);
        end else if (mem.code_ext) begin
          cost = 8'(psx_pkg::CYC_ONE + pw);
        end else begin
          cost = mem.same_single_access_ram ? psx_pkg::CYC_SQR_ALL : psx_pkg::CYC_ONE;
        end
      end
      psx_pkg::PSX_OP_SST: begin
        if (n != 8'h00) begin                                                  // [RL9]
          if (mem.opnd_ext) begin
            cost = mem.code_ext ? 8'((n << 1) + 8'h02 + nd + pw) : 8'((n << 1) + nd);
          end else if (mem.code_ext) begin
            cost = 8'(n + pw);
          end else begin
            cost = mem.same_single_access_ram ? 8'(n + 8'h02) : n;
          end
        end else if (mem.opnd_ext) begin
          cost = mem.code_ext ? 8'(psx_pkg::CYC_SST_ALL + dw + pw)
                              : 8'(psx_pkg::CYC_SST_EXT + dw);
        end else if (mem.code_ext) begin
          cost = 8'(psx_pkg::CYC_ONE + pw);
        end else begin
          cost = mem.same_single_access_ram ? psx_pkg::CYC_SST_EXT : psx_pkg::CYC_ONE;
        end
      end
      psx_pkg::PSX_OP_STORE_LONG_IMMEDIATE_OP: begin                                              // [RL12]
        if (mem.opnd_ext) begin
          cost = mem.code_ext ? 8'(psx_pkg::CYC_STORE_LONG_IMMEDIATE_OP_ALL + dw + (pw << 1))
                              : 8'(psx_pkg::CYC_STORE_LONG_IMMEDIATE_OP_EXT + dw);
        end else if (mem.code_ext) begin
          cost = 8'(psx_pkg::CYC_STORE_LONG_IMMEDIATE_OP + (pw << 1));
        end else begin
          cost = mem.same_single_access_ram ? psx_pkg::CYC_STORE_LONG_IMMEDIATE_OP_SA : psx_pkg::CYC_STORE_LONG_IMMEDIATE_OP;
        end
      end
      default: cost = psx_pkg::CYC_ONE;
    endcase
  end

  // ****************************************
  // Busy counter: holds the core for the cost
  // ****************************************
  logic [7:0] wait_q, wait_d;
  logic       go;

  always_comb begin
    go     = (op != psx_pkg::PSX_OP_NONE) && (wait_q == 8'h00);
    wait_d = wait_q;
    if (go) begin
      wait_d = 8'(cost - 8'h01);
    end else if (wait_q != 8'h00) begin
      wait_d = 8'(wait_q - 8'h01);
    end
    busy = (wait_q != 8'h00);
  end

  // ****************************************
  // Datapath next state
  // ****************************************
  logic [31:0] acc_d, product_register_d;
  logic [15:0] multiplicand_register_d, st0_d, st1_d, wr_addr_d, wr_data_d;
  logic [7:0]  cycles_d;
  logic        wr_en_d;
  logic [32:0] sum;
  logic        ovf;

  always_comb begin
    acc_d     = acc_q;
    product_register_d    = product_register_q;
    multiplicand_register_d    = multiplicand_register_q;
    st0_d     = st0_q;
    st1_d     = st1_q;
    cycles_d  = go ? cost : cycles_q;
    wr_en_d   = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    sum       = 33'h000000000;
    ovf       = 1'b0;
    if (go) begin
      case (op)
        psx_pkg::PSX_OP_SPM: begin
          st1_d[psx_pkg::PM_LSB +: 2] = instr[1:0];                            // [RL1]
        end
        psx_pkg::PSX_OP_LST1: begin
          st1_d = lst_data;                                                    // [RL4]
        end
        psx_pkg::PSX_OP_SQUARE_ACCUMULATE_OP, psx_pkg::PSX_OP_SQUARE_SUBTRACT_OP: begin
          // Uses the shifted view, never the raw product
          if (op == psx_pkg::PSX_OP_SQUARE_ACCUMULATE_OP) begin
            sum = {1'b0, acc_q} + {1'b0, product_register_shifted};                        // [RL3] [RL13]
            ovf = (acc_q[31] == product_register_shifted[31]) && (sum[31] != acc_q[31]);
            st1_d[psx_pkg::C_BIT] = sum[32];
          end else begin
            sum = {1'b0, acc_q} - {1'b0, product_register_shifted};                        // [RL3] [RL13]
            ovf = (acc_q[31] != product_register_shifted[31]) && (sum[31] != acc_q[31]);
            st1_d[psx_pkg::C_BIT] = ~sum[32];
          end
          acc_d = sum[31:0];
          if (ovf) begin
            st0_d[psx_pkg::OV_BIT] = 1'b1;
            if (st0_q[psx_pkg::OVM_BIT]) begin
              acc_d = acc_q[31] ? 32'h80000000 : 32'h7fffffff;
            end
          end
          multiplicand_register_d = rd_data;                                                    // [RL13]
          product_register_d = 32'($signed(rd_data) * $signed(rd_data));
        end
        psx_pkg::PSX_OP_SST: begin
          wr_en_d   = 1'b1;
          wr_addr_d = ea;                                                      // [RL7] [RL8]
          wr_data_d = instr[psx_pkg::SST_SEL_BIT] ? st1_q : st0_q;             // [RL6]
        end
        psx_pkg::PSX_OP_STORE_LONG_IMMEDIATE_OP: begin
          wr_en_d   = 1'b1;
          wr_addr_d = ea;
          wr_data_d = instr_ext;                                               // [RL14]
        end
        default: wr_en_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_q     <= 32'h00000000;
      product_register_q    <= 32'h00000000;
      multiplicand_register_q    <= 16'h0000;
      st0_q     <= psx_pkg::ST0_RST;
      st1_q     <= psx_pkg::ST1_RST;
      cycles_q  <= 8'h00;
      wait_q    <= 8'h00;
      wr_en_q   <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
    end else begin
      acc_q     <= acc_d;
      product_register_q    <= product_register_d;
      multiplicand_register_q    <= multiplicand_register_d;
      st0_q     <= st0_d;
      st1_q     <= st1_d;
      cycles_q  <= cycles_d;
      wait_q    <= wait_d;
      wr_en_q   <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

endmodule : psx_exec

/* File: inc/psx_pkg.sv */
package psx_pkg;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int DW            = 16;
  localparam int PW            = 32;
  localparam int PM_LSB        = 0;
  localparam int OVM_BIT       = 11;
  localparam int OV_BIT        = 12;
  localparam int C_BIT         = 9;
  localparam int SST_SEL_BIT   = 8;
  localparam int IND_BIT       = 7;
  localparam int SHL1          = 1;
  localparam int SHL4          = 4;
  localparam int SHR6          = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] ST0_RST = 16'h0000;
  localparam logic [15:0] ST1_RST = 16'h0000;

  // ****************************************
  // Opcode matches (upper bits of the word)
  // ****************************************
  localparam logic [13:0] OP_SPM_HI  = 14'h2f80;  // bits 15..2
  localparam logic [7:0]  OP_SQUARE_ACCUMULATE_OP_HI = 8'h52;
  localparam logic [7:0]  OP_SQUARE_SUBTRACT_OP_HI = 8'h53;
  localparam logic [7:0]  OP_STORE_LONG_IMMEDIATE_OP_HI = 8'hae;
  localparam logic [6:0]  OP_SST_HI  = 7'h47;     // bits 15..9
  localparam logic [7:0]  OP_LST1_HI = 8'h0f;     // load status word one

  // ****************************************
  // Cycle base costs
  // ****************************************
  localparam logic [7:0] CYC_ONE      = 8'h01;
  localparam logic [7:0] CYC_SST_EXT  = 8'h02;
  localparam logic [7:0] CYC_SST_ALL  = 8'h04;
  localparam logic [7:0] CYC_SQR_ALL  = 8'h02;
  localparam logic [7:0] CYC_STORE_LONG_IMMEDIATE_OP     = 8'h02;
  localparam logic [7:0] CYC_STORE_LONG_IMMEDIATE_OP_SA  = 8'h03;
  localparam logic [7:0] CYC_STORE_LONG_IMMEDIATE_OP_EXT = 8'h03;
  localparam logic [7:0] CYC_STORE_LONG_IMMEDIATE_OP_ALL = 8'h05;

  typedef enum logic [2:0] {
    PSX_OP_NONE, PSX_OP_SPM, PSX_OP_SQUARE_ACCUMULATE_OP, PSX_OP_SQUARE_SUBTRACT_OP, PSX_OP_SST, PSX_OP_STORE_LONG_IMMEDIATE_OP, PSX_OP_LST1
  } psx_op_e;

  // Where operand and code live for one instruction
  typedef struct packed {
    logic       code_ext;
    logic       opnd_ext;
    logic       same_single_access_ram;
    logic [3:0] p_wait;
    logic [3:0] d_wait;
  } psx_mem_s;

endpackage : psx_pkg

/* File: dv/psx_exec_assertions.sv */
`timescale 1ns/1ps
// ****************************************
// Checker on the top ports
// ****************************************
module psx_exec_assertions (
  input wire logic              clk,          // Clock
  input wire logic              nrst,         // Reset
  input wire logic              instr_valid,  // Word present
  input wire logic [15:0]       instr,        // Word
  input wire logic [15:0]       instr_ext,    // Second word
  input wire logic [7:0]        rpt_n,        // Repeat count
  input wire psx_pkg::psx_mem_s mem,          // Placement
  input wire logic [15:0]       ar_in,        // Aux address
  input wire logic              busy,         // Busy
  input wire logic [7:0]        cycles_q,     // Cost
  input wire logic              wr_en_q,      // Write
  input wire logic [15:0]       wr_addr_q,    // Write address
  input wire logic [15:0]       wr_data_q,    // Write data
  input wire logic [31:0]       product_register_q,       // Product
  input wire logic [31:0]       product_register_shifted, // Shifted product
  input wire logic [15:0]       st0_q,        // Status zero
  input wire logic [15:0]       st1_q         // Status one
);
  logic tk, set_product_mode_op, store_status_op, store_long_immediate_op;
  assign tk   = instr_valid && !busy;
  assign set_product_mode_op  = tk && instr[15:2] == psx_pkg::OP_SPM_HI;
  assign store_status_op  = tk && instr[15:9] == psx_pkg::OP_SST_HI;
  assign store_long_immediate_op = tk && instr[15:8] == psx_pkg::OP_STORE_LONG_IMMEDIATE_OP_HI;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_spm_mode:
    assert property (set_product_mode_op |=> st1_q[1:0] == $past(instr[1:0])) else $error("mode not set");
  a_shift_none:
    assert property (st1_q[1:0] == 2'h0 |-> product_register_shifted == product_register_q) else $error("shift 0");
  a_shift_left1:
    assert property (st1_q[1:0] == 2'h1 |-> product_register_shifted == product_register_q << 1) else $error("shift 1");
  a_shift_left4:
    assert property (st1_q[1:0] == 2'h2 |-> product_register_shifted == product_register_q << 4) else $error("shift 4");
  a_shift_right6:
    assert property (st1_q[1:0] == 2'h3 |-> product_register_shifted == 32'($signed(product_register_q) >>> 6))
      else $error("shift 6");
  a_sst_page0:
    assert property (store_status_op && !instr[7] |=> wr_en_q && wr_addr_q == {9'h0, $past(instr[6:0])})
      else $error("page 0");
  a_sst_word:
    assert property (store_status_op |=> wr_data_q == ($past(instr[8]) ? st1_q : st0_q)) else $error("sst");
  a_sst_indirect:
    assert property (store_status_op && instr[7] |=> wr_addr_q == $past(ar_in)) else $error("aux addr");
  a_store_long_immediate_op_word:
    assert property (store_long_immediate_op |=> wr_en_q && wr_data_q == $past(instr_ext)) else $error("store_long_immediate_op");
  a_store_long_immediate_op_cost:
    assert property (store_long_immediate_op && mem == '0 && rpt_n == 8'h0 |=> busy ##1 !busy) else $error("2c");
  a_spm_cost:
    assert property (set_product_mode_op && !mem.code_ext |=> !busy && cycles_q == 8'h01) else $error("1c");
endmodule : psx_exec_assertions

bind psx_exec psx_exec_assertions psx_exec_assertions_inst (.clk(clk), .nrst(nrst),
  .instr_valid(instr_valid), .instr(instr), .instr_ext(instr_ext), .rpt_n(rpt_n), .mem(mem),
  .ar_in(ar_in), .busy(busy), .cycles_q(cycles_q), .wr_en_q(wr_en_q),
  .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .product_register_q(product_register_q),
  .product_register_shifted(product_register_shifted), .st0_q(st0_q), .st1_q(st1_q));

/* File: dv/psx_mem_model.sv */
`timescale 1ns/1ps
// ****************************************
// Data memory model
// ****************************************
module psx_mem_model (
  input  wire logic        clk,     // Clock
  input  wire logic [15:0] rd_addr, // Read address
  output logic      [15:0] rd_data, // Read word
  input  wire logic        wr_en,   // Write strobe
  input  wire logic [15:0] wr_addr, // Write address
  input  wire logic [15:0] wr_data  // Write word
);
  // Only 16 words; upper address bits fold away
  logic [15:0] mem_q [16];
  initial for (int k = 0; k < 16; k++) mem_q[k] = 16'h0b00 + 16'(k);
  always @(posedge clk) if (wr_en) mem_q[wr_addr[3:0]] <= wr_data;
  assign rd_data = mem_q[rd_addr[3:0]];
endmodule : psx_mem_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module tb;
  logic              clk, nrst, instr_valid, busy, wr_en_q, we;
  logic [1:0]        md;
  logic [7:0]        rpt_n, cycles_q;
  logic [8:0]        dp_in;
  logic [15:0]       instr, instr_ext, ar_in, rd_data, lst_data, rd_addr, wa, wd;
  logic [15:0]       wr_addr_q, wr_data_q, multiplicand_register_q, st0_q, st1_q;
  logic [31:0]       acc_q, product_register_q, product_register_shifted, acc_e, pr_e;
  psx_pkg::psx_mem_s mem;
  int                failures, checked, cyc;

  psx_exec psx_exec_inst (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .instr_ext(instr_ext), .rpt_n(rpt_n), .mem(mem), .dp_in(dp_in), .ar_in(ar_in),
    .rd_data(rd_data), .lst_data(lst_data), .busy(busy), .cycles_q(cycles_q),
    .wr_en_q(wr_en_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .rd_addr(rd_addr),
    .acc_q(acc_q), .multiplicand_register_q(multiplicand_register_q), .product_register_q(product_register_q), .product_register_shifted(product_register_shifted),
    .st0_q(st0_q), .st1_q(st1_q));
  psx_mem_model psx_mem_model_inst (.clk(clk), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_en(wr_en_q), .wr_addr(wr_addr_q), .wr_data(wr_data_q));

  task automatic print_verdict;
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  function automatic logic [31:0] shf(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h1: return p << 1;
      2'h2: return p << 4;
      2'h3: return 32'($signed(p) >>> 6);
      default: return p;
    endcase
  endfunction : shf

  // Waits out busy so a refused request is never sent
  task automatic issue(input logic [15:0] i, e, input logic [10:0] m, input logic [7:0] n);
    int k;
    @(posedge clk);
    instr <= i;
    instr_ext <= e;
    mem <= psx_pkg::psx_mem_s'(m);
    rpt_n <= n;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    we = wr_en_q;
    wa = wr_addr_q;
    wd = wr_data_q;
    for (k = 0; k < 40 && busy !== 1'b0; k++) @(posedge clk) #1;
  endtask : issue

  task automatic cost(input logic [15:0] i, input logic [10:0] m, input logic [7:0] n, e);
    issue(i, 16'h0, m, n);
    chk(cycles_q, e);
  endtask : cost

  task automatic sqr(input logic sub, input logic [6:0] a, input logic [15:0] d);
    acc_e = sub ? acc_e - shf(pr_e, md) : acc_e + shf(pr_e, md);
    pr_e = 32'($signed(d) * $signed(d));
    issue({7'h29, sub, 1'h0, a}, 16'h0, 11'h0, 8'h0);
    chk(multiplicand_register_q, d);
    chk(product_register_q, pr_e);
    chk(acc_q, acc_e);
  endtask : sqr

  initial forever #25 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      print_verdict;
    end
  end

  initial begin
    {clk, nrst, instr_valid, instr, instr_ext, rpt_n, dp_in, ar_in, lst_data} = '0;
    {failures, checked, cyc, acc_e, pr_e, md} = '0;
    mem = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    sqr(1'b0, 7'h5, 16'h0b05);
    sqr(1'b0, 7'h5, 16'h0b05);
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      issue({14'h2f80, md}, 16'h0, 11'h0, 8'h0);
      chk(st1_q[1:0], md);
      chk(cycles_q, 8'h01);
      chk(product_register_shifted, shf(pr_e, md));
      chk(product_register_q, pr_e);
      sqr(m[0], 7'h3, 16'h0b03);
      chk(st1_q[psx_pkg::C_BIT], m[0]);
    end
    cost(16'hbe02, 11'h420, 8'h0, 8'h03);
    @(posedge clk) lst_data <= 16'h0001;
    issue(16'h0f00, 16'h0, 11'h0, 8'h0);
    md = 2'h1;
    chk(st1_q[1:0], md);
    @(posedge clk) dp_in <= 9'h0;
    issue(16'hae06, 16'ha5c3, 11'h0, 8'h0);
    chk({we, wa, wd}, {1'b1, 16'h0006, 16'ha5c3});
    chk(cycles_q, 8'h02);
    sqr(1'b0, 7'h6, 16'ha5c3);
    @(posedge clk) {dp_in, ar_in} <= {9'h1ff, 16'h7123};
    issue(16'h8f60, 16'h0, 11'h0, 8'h0);
    chk({we, wa, wd}, {1'b1, 16'h0060, 16'h0001});
    issue(16'h8e80, 16'h0, 11'h0, 8'h0);
    chk({wa, wd}, {16'h7123, 16'h0000});
    chk(cycles_q, 8'h01);
    cost(16'h8f60, 11'h203, 8'h0, 8'h05);
    cost(16'h8f60, 11'h613, 8'h0, 8'h08);
    cost(16'h8f60, 11'h201, 8'h4, 8'h0c);
    cost(16'h5203, 11'h202, 8'h0, 8'h03);
    cost(16'h5303, 11'h612, 8'h0, 8'h05);
    cost(16'h5203, 11'h202, 8'h3, 8'h09);
    cost(16'h5303, 11'h612, 8'h3, 8'h0b);
    cost(16'h5203, 11'h100, 8'h3, 8'h04);
    cost(16'hae06, 11'h100, 8'h0, 8'h03);
    cost(16'hae06, 11'h201, 8'h0, 8'h04);
    cost(16'hae06, 11'h621, 8'h0, 8'h0a);
    print_verdict;
  end
endmodule : tb
